// ===== slfp_pkg.sv
package slfp_pkg;
	// framing byte values
	localparam logic [7:0] SYNC_BYTE   = 8'hFF;
	localparam logic [7:0] ESCAPE_BYTE = 8'hFE;
	localparam logic [7:0] END_COUNT   = 8'h00;
	// address byte layout
	localparam int         ADDR_LSB    = 0;
	localparam int         ADDR_WIDTH  = 3;
	localparam int         SWITCH_BIT  = 7;
	// link byte width and bit counter
	localparam int         BYTE_WIDTH  = 8;
	localparam logic [2:0] LAST_BIT    = 3'h7;
	// reset values
	localparam logic       CHIP_RESET  = 1'h0;
	localparam logic [7:0] DATA_RESET  = 8'h00;
	// lcd register select encoding
	localparam logic       RS_INSTR    = 1'h0;
	localparam logic       RS_DATA     = 1'h1;

	typedef enum logic [3:0] {
		ST_SYNC    = 4'h1,
		ST_ADDR    = 4'h2,
		ST_COUNT   = 4'h4,
		ST_PAYLOAD = 4'h8
	} slfp_state_type;
endpackage

// ===== slfp_byte_if.sv
`timescale 1ns/1ns
// carries each received byte and its event toggle from the link domain
interface slfp_byte_if;
	logic [7:0] rxByte;
	logic       rxToggle;

	modport rx (output rxByte, output rxToggle);
	modport parser (input rxByte, input rxToggle);
endinterface

// ===== slfp_spi_rx.sv
`timescale 1ns/1ns
// spi slave byte receiver, mode 0, msb first, clocked by the link clock
module slfp_spi_rx (
	input  wire logic   spiSclk,
	input  wire logic   spiCsN,
	input  wire logic   spiMosi,
	slfp_byte_if.rx     link
);
	logic [2:0] bitCnt_reg;
	logic [6:0] shift_reg;
	logic [7:0] byte_reg   = slfp_pkg::DATA_RESET;
	logic       toggle_reg = 1'h0; // no link-side reset exists; power-up value keeps the crossing defined

	// bit position restarts whenever chip select is released, so a torn byte never lingers
	always_ff @(posedge spiSclk or posedge spiCsN) begin
		if (spiCsN) begin
			bitCnt_reg <= 3'h0;
		end else begin
			bitCnt_reg <= bitCnt_reg + 3'h1;
		end
	end

	// shift in on rising edge
	always_ff @(posedge spiSclk) begin
		shift_reg <= {shift_reg[5:0], spiMosi};
	end

	// whole byte: hold it and flip the toggle; the byte stays put for the next seven link edges
	always_ff @(posedge spiSclk) begin
		if (!spiCsN && bitCnt_reg == slfp_pkg::LAST_BIT) begin
			byte_reg   <= {shift_reg, spiMosi};
			toggle_reg <= ~toggle_reg;
		end
	end

	assign link.rxByte   = byte_reg;
	assign link.rxToggle = toggle_reg;
endmodule

// ===== slfp_parser.sv
`timescale 1ns/1ns
// Notes on behaviour
// - skip incoming bytes until the FF sync byte, then expect the address byte.
// - low three address bits must equal the board address; bits 6..3 ignored.
// - board address comes from three straps, first strap is bit 0, fitted is one.
// - address top bit set toggles which of two display controllers gets output, only when the low three bits match.
// - third byte is payload length 1..255; zero ends the frame without payload.
// - FE marks the next payload byte as a command for the instruction register.
module slfp_parser (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       spiSclk,
	input  wire logic       spiCsN,
	input  wire logic       spiMosi,
	input  wire logic [2:0] addrStrap,
	output logic      [7:0] lcdData,
	output logic            lcdRs,
	output logic            lcdWrite,
	output logic            lcdChipSel
);
	// byte and toggle handed over from the link domain
	slfp_byte_if                link ();

	// pin and crossing flops
	logic [2:0]                 strapSync1_reg;
	logic [2:0]                 strapSync2_reg;
	logic                       tglSync1_reg;
	logic                       tglSync2_reg;
	logic                       tglSeen_reg;

	// frame sequencer and per-frame state
	slfp_pkg::slfp_state_type   state_reg;
	slfp_pkg::slfp_state_type   state_next;
	logic [7:0]                 count_reg;
	logic                       match_reg;
	logic                       escape_reg;
	logic                       chip_reg;

	// display output flops
	logic [7:0]                 data_reg;
	logic                       rs_reg;
	logic                       write_reg;

	// decode helpers
	logic                       byteValid;
	logic [7:0]                 rxByte;
	logic                       addrHit;
	logic                       lastPayload;
	logic                       writeHit;

	// link-side receiver, runs on the link clock only
	slfp_spi_rx u_rx (
		.spiSclk (spiSclk),
		.spiCsN  (spiCsN),
		.spiMosi (spiMosi),
		.link    (link)
	);

	// straps are pins, so they pass two flops before use
	always_ff @(posedge clk) begin
		if (srst) begin
			strapSync1_reg <= 3'h0;
			strapSync2_reg <= 3'h0;
		end else begin
			strapSync1_reg <= addrStrap;
			strapSync2_reg <= strapSync1_reg;
		end
	end

	// byte event crossing: toggle through two flops, edge taken on the settled copy;
	// no reset, so the chain follows the link during srst and no false edge follows it
	always_ff @(posedge clk) begin
		tglSync1_reg <= link.rxToggle;
		tglSync2_reg <= tglSync1_reg;
		tglSeen_reg  <= tglSync2_reg;
	end

	// data word has been stable for several cycles by the time the edge shows here
	assign byteValid   = tglSync2_reg ^ tglSeen_reg;
	assign rxByte      = link.rxByte;

	// address compare and last-byte decode
	assign addrHit     = rxByte[slfp_pkg::ADDR_LSB +: slfp_pkg::ADDR_WIDTH] == strapSync2_reg;
	assign lastPayload = count_reg == 8'h01;

	// frame sequencer
	always_comb begin
		state_next = state_reg;
		if (byteValid) begin
			case (state_reg)
				slfp_pkg::ST_SYNC: begin
					if (rxByte == slfp_pkg::SYNC_BYTE) begin
						state_next = slfp_pkg::ST_ADDR;
					end
				end
				slfp_pkg::ST_ADDR: begin
					state_next = slfp_pkg::ST_COUNT;
				end
				slfp_pkg::ST_COUNT: begin
					if (rxByte == slfp_pkg::END_COUNT) begin
						state_next = slfp_pkg::ST_SYNC;
					end else begin
						state_next = slfp_pkg::ST_PAYLOAD;
					end
				end
				slfp_pkg::ST_PAYLOAD: begin
					if (lastPayload) begin
						state_next = slfp_pkg::ST_SYNC;
					end
				end
				default: begin
					state_next = slfp_pkg::ST_SYNC;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= slfp_pkg::ST_SYNC;
		end else begin
			state_reg <= state_next;
		end
	end

	// address match is latched per frame and gates every display write; the controller switch uses addrHit directly
	always_ff @(posedge clk) begin
		if (srst) begin
			match_reg <= 1'h0;
		end else if (byteValid && state_reg == slfp_pkg::ST_ADDR) begin
			match_reg <= addrHit;
		end
	end

	// controller switch, only for a frame aimed at this board
	always_ff @(posedge clk) begin
		if (srst) begin
			chip_reg <= slfp_pkg::CHIP_RESET;
		end else if (byteValid && state_reg == slfp_pkg::ST_ADDR && addrHit && rxByte[slfp_pkg::SWITCH_BIT]) begin
			chip_reg <= ~chip_reg;
		end
	end

	// remaining payload count; foreign frames are counted out too so the sync hunt resumes cleanly
	always_ff @(posedge clk) begin
		if (srst) begin
			count_reg <= 8'h00;
		end else if (byteValid && state_reg == slfp_pkg::ST_COUNT) begin
			count_reg <= rxByte;
		end else if (byteValid && state_reg == slfp_pkg::ST_PAYLOAD) begin
			count_reg <= count_reg - 8'h01;
		end
	end

	// escape tracking; an escape that is the last payload byte is dropped with the frame
	always_ff @(posedge clk) begin
		if (srst) begin
			escape_reg <= 1'h0;
		end else if (byteValid && state_reg == slfp_pkg::ST_PAYLOAD) begin
			if (escape_reg) begin
				escape_reg <= 1'h0;
			end else begin
				escape_reg <= rxByte == slfp_pkg::ESCAPE_BYTE && !lastPayload;
			end
		end else if (state_reg != slfp_pkg::ST_PAYLOAD) begin
			escape_reg <= 1'h0;
		end
	end

	// a payload byte of a matching frame is written unless it is the escape itself;
	// an escape in the last slot is not written either, since escape_reg stays clear; it is dropped with the frame
	always_comb begin
		writeHit = 1'h0;
		if (byteValid && state_reg == slfp_pkg::ST_PAYLOAD && match_reg) begin
			if (escape_reg) begin
				writeHit = 1'h1;
			end else if (rxByte != slfp_pkg::ESCAPE_BYTE) begin
				writeHit = 1'h1;
			end
		end
	end

	// write strobe, one cycle wide, lines up with the data and select it qualifies
	always_ff @(posedge clk) begin
		if (srst) begin
			write_reg <= 1'h0;
		end else begin
			write_reg <= writeHit;
		end
	end

	// output byte is held between writes, so a slow display bus may take it late
	always_ff @(posedge clk) begin
		if (srst) begin
			data_reg <= slfp_pkg::DATA_RESET;
		end else if (writeHit) begin
			data_reg <= rxByte;
		end
	end

	// register select: instruction after an escape, character data otherwise
	always_ff @(posedge clk) begin
		if (srst) begin
			rs_reg <= slfp_pkg::RS_DATA;
		end else if (writeHit && escape_reg) begin
			rs_reg <= slfp_pkg::RS_INSTR;
		end else if (writeHit) begin
			rs_reg <= slfp_pkg::RS_DATA;
		end
	end

	// outputs come straight from their flops
	assign lcdData    = data_reg;
	assign lcdRs      = rs_reg;
	assign lcdWrite   = write_reg;
	assign lcdChipSel = chip_reg;
endmodule

// ===== slfp_parser_asserts.sv
`timescale 1ns/1ns
module slfp_parser_asserts (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       spiSclk,
	input wire logic       spiCsN,
	input wire logic       spiMosi,
	input wire logic [2:0] addrStrap,
	input wire logic [7:0] lcdData,
	input wire logic       lcdRs,
	input wire logic       lcdWrite,
	input wire logic       lcdChipSel
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	int idleCnt;
	// cycles since select went high, saturating so it never wraps
	always_ff @(posedge clk) begin
		idleCnt <= (srst || (spiCsN && idleCnt >= 50)) ? 50 : (spiCsN ? idleCnt + 1 : 0);
	end
	// a byte takes about ten clocks, so no output action lands closer
	sequence quietSpan;
		!lcdWrite [*5];
	endsequence
	chk_write_pulse: assert property (lcdWrite |=> quietSpan)
		else $error("write pulses too close");
	chk_chip_quiet: assert property ($changed(lcdChipSel) |-> quietSpan)
		else $error("write too soon after chip switch");
	chk_write_link: assert property (lcdWrite |-> idleCnt < 8)
		else $error("write without link traffic");
	chk_chip_link: assert property ($changed(lcdChipSel) |-> idleCnt < 8)
		else $error("chip switch without link traffic");
	chk_start_quiet: assert property ($fell(srst) |-> quietSpan)
		else $error("write right after reset");
	chk_data_hold: assert property (!lcdWrite |-> $stable(lcdData) && $stable(lcdRs))
		else $error("output byte moved without a write");
	chk_reset_vals: assert property (disable iff (1'b0) srst |=> !lcdWrite && !lcdChipSel && lcdRs)
		else $error("bad outputs in reset");
endmodule
bind slfp_parser slfp_parser_asserts i_chk (.clk(clk), .srst(srst), .spiSclk(spiSclk), .spiCsN(spiCsN),
	.spiMosi(spiMosi), .addrStrap(addrStrap), .lcdData(lcdData), .lcdRs(lcdRs), .lcdWrite(lcdWrite),
	.lcdChipSel(lcdChipSel));

// ===== slfp_spi_host.sv
`timescale 1ns/1ns
// mode 0 host: clock idles low and stands still between frames
module slfp_spi_host (
	output logic spiSclk,
	output logic spiCsN,
	output logic spiMosi
);
	initial begin
		spiSclk = 1'h0;
		spiCsN = 1'h1;
		spiMosi = 1'h1;
	end
	task automatic send(input logic [7:0] b[$]);
		#7 spiCsN = 1'h0;
		foreach (b[i]) for (int k = 7; k >= 0; k--) begin
			spiMosi = b[i][k];
			#6 spiSclk = 1'h1;
			#6 spiSclk = 1'h0;
		end
		#6 spiCsN = 1'h1;
		spiMosi = ~spiMosi; // a released line must not keep the last bit
	endtask
endmodule

// ===== slfp_parser_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin errTotal++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module slfp_parser_bench;
	logic       clk = 1'h0;
	logic       srst = 1'h1;
	logic       sclk, csN, mosi, lcdRs, lcdWrite, lcdChipSel;
	logic [2:0] strap = 3'h1;
	logic [7:0] lcdData;
	logic [8:0] got[$];
	int         errTotal = 0;
	int         checksDone = 0;
	always #5 clk = ~clk;
	slfp_parser i_slfp_parser (.clk(clk), .srst(srst), .spiSclk(sclk), .spiCsN(csN), .spiMosi(mosi),
		.addrStrap(strap), .lcdData(lcdData), .lcdRs(lcdRs), .lcdWrite(lcdWrite), .lcdChipSel(lcdChipSel));
	slfp_spi_host i_slfp_spi_host (.spiSclk(sclk), .spiCsN(csN), .spiMosi(mosi));
	// log every display write as select bit and byte
	always @(posedge clk) begin
		if (lcdWrite === 1'h1) got.push_back({lcdRs, lcdData});
	end
	task wrap_up;
		$display("errors %0d checks %0d", errTotal, checksDone);
		if (errTotal == 0 && checksDone > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// send one frame, wait a bounded time for n writes
	task frame(input logic [7:0] b[$], input int n);
		got.delete();
		i_slfp_spi_host.send(b);
		for (int k = 0; k < 40 && got.size() < n; k++) @(posedge clk);
		repeat (10) @(posedge clk);
		`CHK(got.size(), n)
		if (got.size() != n) wrap_up();
	endtask
	task s_data_cmd;
		frame('{8'h55, 8'hFF, 8'h81, 8'h03, 8'h41, 8'hFE, 8'h01}, 2);
		`CHK(got[0], 9'h141)
		`CHK(got[1], 9'h001)
		`CHK(lcdChipSel, 1'h1)
	endtask
	task s_foreign;
		frame('{8'hFF, 8'h82, 8'h02, 8'h41, 8'h42}, 0);
		`CHK(lcdChipSel, 1'h1)
		frame('{8'hFF, 8'h01, 8'h00}, 0);
		frame('{8'hFF, 8'h79, 8'h01, 8'h33}, 1);
		`CHK(got[0], 9'h133)
	endtask
	task s_two_cmd;
		frame('{8'hFF, 8'h81, 8'h05, 8'hFE, 8'h38, 8'hFE, 8'h0E, 8'hFE}, 2);
		`CHK(got[0], 9'h038)
		`CHK(got[1], 9'h00E)
		`CHK(lcdChipSel, 1'h0)
		frame('{8'hFF, 8'h01, 8'h02, 8'hFE, 8'hFE}, 1);
		`CHK(got[0], 9'h0FE)
	endtask
	task s_strap;
		@(posedge clk) strap <= 3'h6;
		repeat (5) @(posedge clk);
		frame('{8'hFF, 8'h06, 8'h01, 8'h5A}, 1);
		`CHK(got[0], 9'h15A)
	endtask
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'h0;
		repeat (5) @(posedge clk);
		`CHK({lcdChipSel, lcdRs, lcdData}, 10'h100)
		s_data_cmd();
		s_foreign();
		s_two_cmd();
		s_strap();
		wrap_up();
	end
endmodule
